// ### bench/ebnw_mem_model.sv
// Behavioural external memory: SRAM cells, NAND command and status, ready.
// Assumes one clock and the block's registered strobes, all active low.
`timescale 1ns/1ps
`default_nettype none
module ebnw_mem_model
#(
  parameter logic [15:0] STAT = 16'h00e0
)
(
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        resetn,
  // Memory pins
  input  wire logic [7:0]  cs_n,
  input  wire logic        oe_n,
  input  wire logic        we_n,
  input  wire logic        nre_n,
  input  wire logic        nwe_n,
  input  wire logic        cle,
  input  wire logic [7:0]  addr,
  input  wire logic [15:0] wdata,
  output logic [15:0]      rdata,
  output logic             rdy,
  // Cycles of ready low after each strobe fall
  input  wire logic [3:0]  stall
);
  logic [15:0] mem [0:255];
  logic [15:0] last_q;
  logic [15:0] val;
  logic [7:0]  last_cmd;
  logic [3:0]  prev_n;
  logic [3:0]  cnt;
  logic        rd;
  logic        fall;
  assign rd   = !(&cs_n) && (!oe_n || !nre_n);
  assign val  = (!nre_n && last_cmd == 8'h70) ? STAT : mem[addr];
  assign fall = |(prev_n & ~{oe_n, we_n, nre_n, nwe_n});
  // A released bus shows the inverse of the last value, never a stale copy.
  assign rdata = rd ? val : ~last_q;
  assign rdy   = (cnt == 4'h0);
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      cnt      <= 4'h0;
      prev_n   <= 4'hf;
      last_q   <= 16'h0000;
      last_cmd <= 8'h00;
    end
    else
    begin
      prev_n <= {oe_n, we_n, nre_n, nwe_n};
      if (rd)
        last_q <= val;
      if (!we_n && !(&cs_n))
        mem[addr] <= wdata;
      if (!nwe_n && cle)
        last_cmd <= wdata[7:0];
      // Ready drops one cycle after the strobe falls, far ahead of its rise, and once high
      // it stays high until the next strobe falls.
      if (fall)
        cnt <= stall;
      else if (cnt != 4'h0)
        cnt <= cnt - 4'h1;
    end
  end
endmodule  // ebnw_mem_model
`default_nettype wire

// ### bench/tb_ebnw_top.sv
// Self-checking bench for the memory bus block: NAND, timing and ready.
// Assumes area 0 is NAND, area 1 SRAM, and the model in ebnw_mem_model.
`timescale 1ns/1ps
`default_nettype none
module tb_ebnw_top;
  localparam logic [31:0] TIM  = 32'h05200051;
  localparam int          STRB = 3;
  localparam logic [31:0] TIM_RDY = 32'h0fa000f1;
  logic        ref_clk, resetn, req, req_write, ack;
  logic        dpoe, oe_n, we_n, alat, nale, ncle, nre_n, nwe_n, rdy;
  logic [2:0]  req_area;
  logic [24:0] req_addr, addr_out;
  logic [15:0] req_wdata, rdata, dpo, dpi, d;
  logic [7:0]  nand_mode, mux_mode, rdy_enable, cs_n;
  logic [95:0] ltim;
  logic [255:0] tim_w;
  logic [3:0]  stall;
  logic [16:0] notes[$];
  logic [16:0] nt;
  int          num_errors = 0;
  int          checked = 0;
  int          cyc = 0;
  int          wlo, nwlo, nrlo, cle_seen, ale_seen, cs_bad, alat_n, drv_n;

  ebnw_top uut (.ref_clk(ref_clk), .resetn(resetn), .req(req),
    .req_write(req_write), .req_area(req_area), .req_addr(req_addr),
    .req_wdata(req_wdata), .ack(ack), .rdata(rdata),
    .nand_mode(nand_mode), .mux_mode(mux_mode), .page_mode(8'h00),
    .rdy_enable(rdy_enable), .oe_width_select(8'h00),
    .cycle_timing_reg(tim_w), .latch_timing_reg(ltim),
    .addr_out(addr_out), .data_pins_o(dpo), .data_pins_oe(dpoe),
    .data_pins_i(dpi), .chip_select_n(cs_n), .output_enable_n(oe_n),
    .write_strobe_n(we_n), .addr_latch(alat), .nand_addr_latch(nale),
    .nand_cmd_latch(ncle), .nand_read_strobe_n(nre_n),
    .nand_write_strobe_n(nwe_n), .ext_ready_in(rdy));

  ebnw_mem_model mdl (.ref_clk(ref_clk), .resetn(resetn), .cs_n(cs_n),
    .oe_n(oe_n), .we_n(we_n), .nre_n(nre_n), .nwe_n(nwe_n), .cle(ncle),
    .addr(addr_out[7:0]), .wdata(dpo), .rdata(dpi), .rdy(rdy),
    .stall(stall));

  initial
  begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // One access, held until ack; strobe and latch cycles are tallied.
  task automatic access(input logic [2:0] area, input logic wr,
                        input logic [15:0] ofs, input logic [15:0] wd,
                        input logic chk, input logic [15:0] exp);
    int n;
    @(negedge ref_clk);
    {wlo, nwlo, nrlo, cle_seen, ale_seen, alat_n, drv_n} = '0;
    notes.push_back({chk, exp});
    req_write = wr;
    req_area  = area;
    req_addr  = {9'h000, ofs};
    req_wdata = wd;
    req       = 1'b1;
    for (n = 0; n < 300 && ack !== 1'b1; n++)
    begin
      @(negedge ref_clk);
      wlo      += (we_n === 1'b0);
      nwlo     += (nwe_n === 1'b0);
      nrlo     += (nre_n === 1'b0);
      cle_seen += (nwe_n === 1'b0 && ncle === 1'b1);
      ale_seen += (nwe_n === 1'b0 && nale === 1'b1);
      cs_bad   += (cs_n[0] !== 1'b0);
      alat_n   += (alat === 1'b1);
      drv_n    += (dpoe === 1'b1);
    end
    check("ack", ack, 1);
    req = 1'b0;
  endtask

  // Read data is compared against the oldest note when ack appears.
  always @(negedge ref_clk)
    if (ack === 1'b1 && notes.size() > 0)
    begin
      nt = notes.pop_front();
      if (nt[16])
        check("rdata", rdata, nt[15:0]);
    end

  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      num_errors++;
      wrap_up();
    end
  end

  initial
  begin
    {req, req_write, req_area, req_addr, req_wdata} = '0;
    nand_mode  = 8'h01;
    rdy_enable = 8'h00;
    mux_mode   = 8'h00;
    tim_w      = {8{TIM}};
    stall      = 4'h0;
    resetn     = 1'b0;
    cs_bad     = 0;
    d          = 16'($urandom(48256));
    ltim       = {$urandom, $urandom, $urandom};
    ltim[23:12] = 12'h521;
    repeat (12) @(negedge ref_clk);
    resetn = 1'b1;
    // --------------------------------------------------------------
    // Page program with an SRAM access during the busy time
    // --------------------------------------------------------------
    access(0, 1, 16'h1000, 16'h0080, 0, 0);
    check("cmd latch", cle_seen, STRB);
    check("nand strobe", nwlo, STRB);
    check("sram strobe idle", wlo, 0);
    access(0, 1, 16'h2000, 16'h0012, 0, 0);
    check("addr latch", ale_seen, STRB);
    check("addr no cmd", cle_seen, 0);
    access(0, 1, 16'h2000, 16'h0034, 0, 0);
    check("addr held", nale, 1);
    access(0, 1, 16'h3000, 16'h0000, 0, 0);
    check("release cycle", nwlo + nrlo, 0);
    @(negedge ref_clk);
    check("release drop", nale, 0);
    access(0, 1, 16'h2000, 16'h0056, 0, 0);
    access(0, 1, 16'h0000, d, 0, 0);
    check("data latches", ale_seen + cle_seen, 0);
    check("data drops addr", nale, 0);
    access(0, 1, 16'h1000, 16'h0010, 0, 0);
    d = 16'($urandom);
    access(1, 1, 16'h0004, d, 0, 0);
    check("sram strobe", wlo, STRB);
    check("sram drive", drv_n > 0, 1);
    check("mux latch idle", alat_n, 0);
    access(1, 0, 16'h0004, 16'h0000, 1, d);
    check("read no drive", drv_n, 0);
    access(0, 1, 16'h1000, 16'h0070, 0, 0);
    access(0, 0, 16'h0000, 16'h0000, 1, 16'h00e0);
    check("nand read strobe", nrlo > 0, 1);
    check("cs held", cs_bad, 0);
    $display("test page program done");
    // --------------------------------------------------------------
    // External ready stretches SRAM cycles but not NAND cycles
    // --------------------------------------------------------------
    rdy_enable = 8'h03;
    stall      = 4'h8;
    // Area 1 gets strobes long enough for a low ready to arrive in time.
    tim_w[63:32] = TIM_RDY;
    d = 16'($urandom);
    access(1, 1, 16'h0008, d, 0, 0);
    check("ready stretch", wlo > 11 && wlo < 19, 1);
    access(1, 0, 16'h0008, 16'h0000, 1, d);
    mux_mode = 8'h03;
    access(1, 1, 16'h000c, d, 0, 0);
    check("mux latch", alat_n, 3);
    access(0, 1, 16'h0000, d, 0, 0);
    check("nand no stretch", nwlo, STRB);
    check("nand no mux", alat_n, 0);
    check("cs held", cs_bad, 0);
    $display("test external ready done");
    wrap_up();
  end
endmodule  // tb_ebnw_top
`default_nettype wire

// ### src/ebnw_map.svh
// Offsets, field layouts and timing figures of the NAND-capable memory bus.
// Included by the sequencer and top design files; definitions only.
`ifndef EBNW_MAP_SVH
`define EBNW_MAP_SVH
// NAND window decode, taken from the access offset bits [13:12].
`define EBNW_OFS_DATA      2'h0
`define EBNW_OFS_CMD       2'h1
`define EBNW_OFS_ADDR      2'h2
`define EBNW_OFS_RELEASE   2'h3
`define EBNW_OFS_HI        13
`define EBNW_OFS_LO        12
// Timing field slices of the cycle timing word.
`define EBNW_READ_STROBE_DELAY_HI       3
`define EBNW_READ_STROBE_DELAY_LO       0
`define EBNW_READ_CYCLE_LEN_HI       7
`define EBNW_READ_CYCLE_LEN_LO       4
`define EBNW_READ_IDLE_LEN_HI      11
`define EBNW_READ_IDLE_LEN_LO      8
`define EBNW_FIRST_READ_WAIT_HI      15
`define EBNW_FIRST_READ_WAIT_LO      12
`define EBNW_WRITE_STROBE_DELAY_HI       19
`define EBNW_WRITE_STROBE_DELAY_LO       16
`define EBNW_WRITE_PULSE_LEN_HI       23
`define EBNW_WRITE_PULSE_LEN_LO       20
`define EBNW_WRITE_CYCLE_LEN_HI       27
`define EBNW_WRITE_CYCLE_LEN_LO       24
`define EBNW_WRITE_IDLE_LEN_HI      31
`define EBNW_WRITE_IDLE_LEN_LO      28
// Latch timing word slices.
`define EBNW_LATCH_START_DELAY_HI       3
`define EBNW_LATCH_START_DELAY_LO       0
`define EBNW_LATCH_PULSE_WIDTH_HI       7
`define EBNW_LATCH_PULSE_WIDTH_LO       4
`define EBNW_ALC_HI        11
`define EBNW_ALC_LO        8
// Ready handling: strobe rises this many cycles after ready is seen high,
// and a low ready counts only when seen this many cycles before the rise.
`define EBNW_RDY_LEAD      5'h02
`define EBNW_ONE           5'h01
`define EBNW_ZERO          5'h00
`endif

// ### src/ebnw_pkg.sv
// Types shared by the memory bus block and its sequencer.
// Assumes ebnw_map.svh is on the include path.
package ebnw_pkg;
  typedef enum logic [5:0] {
    EBNW_IDLE  = 6'h01,
    EBNW_ADDR  = 6'h02,
    EBNW_DLY   = 6'h04,
    EBNW_STRB  = 6'h08,
    EBNW_HOLD  = 6'h10,
    EBNW_GAP   = 6'h20
  } ebnw_state_t;
endpackage

// ### src/ebnw_seq.sv
// Cycle sequencer: address phase, strobe delay, strobe, hold and idle gap.
// Assumes the top loads a fully resolved timing set with start.
`timescale 1ns/1ps
`default_nettype none
`include "ebnw_map.svh"
module ebnw_seq
(
  // Clock and reset
  input wire logic  ref_clk,
  input wire logic  resetn,
  // Ready, already synchronised
  input wire logic  rdy_sync,
  // Control carrier
  ebnw_seq_if.seq   s
);
  import ebnw_pkg::*;

  ebnw_state_t state_r;
  logic [4:0]  cnt_r;
  logic [4:0]  tot_r;
  logic [4:0]  rdy_cnt_r;
  logic        stall_r;

  function automatic logic [4:0] ext(input logic [3:0] v);
    ext = {1'b0, v};
  endfunction

  // --------------------------------------------------------------------
  // Phase stepping
  // --------------------------------------------------------------------
  // Ready is honoured only while the strobe is low and more than the lead
  // remains; a late low is dropped so the strobe edge stays predictable.
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_r   <= EBNW_IDLE;
      cnt_r     <= `EBNW_ZERO;
      tot_r     <= `EBNW_ZERO;
      stall_r   <= 1'b0;
      rdy_cnt_r <= `EBNW_ZERO;
    end
    else
    begin
      case (state_r)
        EBNW_IDLE:
        begin
          if (s.start)
          begin
            tot_r   <= `EBNW_ONE;
            cnt_r   <= `EBNW_ONE;
            stall_r <= 1'b0;
            state_r <= s.mux ? EBNW_ADDR : EBNW_DLY;
          end
        end
        EBNW_ADDR:
        begin
          // No stretch here on ready.
          tot_r <= tot_r + `EBNW_ONE;
          if (cnt_r >= ext(s.addr_phase_len) + `EBNW_ONE)
          begin
            cnt_r   <= `EBNW_ONE;
            state_r <= EBNW_DLY;
          end
          else
            cnt_r <= cnt_r + `EBNW_ONE;
        end
        EBNW_DLY:
        begin
          tot_r <= tot_r + `EBNW_ONE;
          if (cnt_r >= ext(s.dly))
          begin
            cnt_r   <= `EBNW_ONE;
            state_r <= EBNW_STRB;
          end
          else
            cnt_r <= cnt_r + `EBNW_ONE;
        end
        EBNW_STRB:
        begin
          tot_r <= tot_r + `EBNW_ONE;
          if (stall_r)
          begin
            // Rise the strobe two cycles after ready returns high.
            if (rdy_sync)
            begin
              if (rdy_cnt_r >= `EBNW_RDY_LEAD - `EBNW_ONE)
              begin
                stall_r <= 1'b0;
                state_r <= EBNW_HOLD;
              end
              else
                rdy_cnt_r <= rdy_cnt_r + `EBNW_ONE;
            end
          end
          else if (s.use_rdy && !rdy_sync &&
                   cnt_r + `EBNW_RDY_LEAD <= ext(s.width) + `EBNW_ONE)
          begin
            stall_r   <= 1'b1;
            rdy_cnt_r <= `EBNW_ZERO;
          end
          else if (cnt_r >= ext(s.width) + `EBNW_ONE)
          begin
            state_r <= EBNW_HOLD;
          end
          else
            cnt_r <= cnt_r + `EBNW_ONE;
        end
        EBNW_HOLD:
        begin
          tot_r <= tot_r + `EBNW_ONE;
          // Chip-select active period measured from access start.
          if (tot_r >= ext(s.cyc) + `EBNW_ONE)
          begin
            cnt_r   <= `EBNW_ONE;
            state_r <= EBNW_GAP;
          end
        end
        EBNW_GAP:
        begin
          if (cnt_r >= ext(s.idle) + `EBNW_ONE)
            state_r <= EBNW_IDLE;
          else
            cnt_r <= cnt_r + `EBNW_ONE;
        end
        default:
          state_r <= EBNW_IDLE;
      endcase
    end
  end

  assign s.busy    = (state_r != EBNW_IDLE);
  assign s.done    = (state_r == EBNW_GAP) &&
                     (cnt_r >= ext(s.idle) + `EBNW_ONE);
  assign s.cs_act  = (state_r == EBNW_ADDR) || (state_r == EBNW_DLY) ||
                     (state_r == EBNW_STRB) || (state_r == EBNW_HOLD);
  assign s.strobe  = (state_r == EBNW_STRB);
  assign s.addr_ph = (state_r == EBNW_ADDR);
  assign s.ale     = (state_r == EBNW_ADDR) &&
                     (cnt_r > ext(s.latch_start_delay)) &&
                     (cnt_r <= ext(s.latch_start_delay) + ext(s.latch_pulse_width) + `EBNW_ONE);

  AST_STROBE_AFTER_ADDR: assert property (@(posedge ref_clk)
    disable iff (!resetn) $rose(s.strobe) |-> !s.addr_ph)
    else $error("strobe rose in address phase");
  AST_NO_STRETCH_ADDR: assert property (@(posedge ref_clk)
    disable iff (!resetn) s.addr_ph |-> ##[1:17] !s.addr_ph)
    else $error("address phase overran its length");

endmodule // ebnw_seq
`default_nettype wire

// ### src/ebnw_seq_if.sv
// Carrier between the access top and its cycle sequencer.
// Assumes one clock domain; the top drives start and timing.
`timescale 1ns/1ps
`default_nettype none
interface ebnw_seq_if;
  logic       start;
  logic       is_write;
  logic       mux;
  logic       page;
  logic       use_rdy;
  logic [3:0] latch_start_delay;
  logic [3:0] latch_pulse_width;
  logic [3:0] addr_phase_len;
  logic [3:0] dly;
  logic [3:0] width;
  logic [3:0] cyc;
  logic [3:0] idle;
  logic       busy;
  logic       done;
  logic       cs_act;
  logic       strobe;
  logic       ale;
  logic       addr_ph;
  modport top (output start, is_write, mux, page, use_rdy, latch_start_delay, latch_pulse_width, addr_phase_len,
               dly, width, cyc, idle,
               input busy, done, cs_act, strobe, ale, addr_ph);
  modport seq (input start, is_write, mux, page, use_rdy, latch_start_delay, latch_pulse_width, addr_phase_len,
               dly, width, cyc, idle,
               output busy, done, cs_act, strobe, ale, addr_ph);
endinterface
`default_nettype wire

// ### src/ebnw_top.sv
// External memory access block with NAND mapping, cycle timing and ready.
// Assumes a bus master presents one access with req and waits for ack.
// Functional notes
// - NAND write at +0x2000 is an address cycle with address latch high.
// - NAND write at +0x1000 is a command cycle with command latch high.
// - NAND access at +0x0000 is a data cycle, command latch low; only a write there drops the address latch.
// - NAND cycles use the same per-area timing as SRAM cycles.
// - Command latch follows the chip-select active timing (cs_act) of an access.
// - Address latch stays high across address writes until release or other.
// - NAND write at +0x3000 only drops the address latch, no memory cycle.
// - Multiplexed mode is not used for a NAND area.
// - Chip select held low continuously while NAND mode is on.
// - Other areas stay accessible while a NAND operation runs.
// - Mux latch start LATCH_START_DELAY, width LATCH_PULSE_WIDTH+1, address phase ADDR_PHASE_LEN+1 cycles.
// - Read strobe after READ_STROBE_DELAY, chip select READ_CYCLE_LEN+1, idle READ_IDLE_LEN+1.
// - First-read wait or oe width FIRST_READ_WAIT+1 as page and width select say.
// - Write strobe after WRITE_STROBE_DELAY+1, low WRITE_PULSE_LEN+1, chip select WRITE_CYCLE_LEN+1, idle.
// - Wait settings apply in all modes; latch timing only in mux mode.
// - Low ready inserts wait cycles stretching the access.
// - Ready low counts only if seen two cycles before strobe rise.
// - Strobe rises two cycles after ready is seen high again.
// - Ready is ignored in page reads and NAND accesses.
// - Address phase and latch pulse never stretch on ready.
`timescale 1ns/1ps
`default_nettype none
`include "ebnw_map.svh"
module ebnw_top
#(
  parameter int AREAS = 8,
  parameter int DW    = 16,
  parameter int AW    = 25
)
(
  // Clock and reset
  input  wire logic                      ref_clk,
  input  wire logic                      resetn,
  // Access request from the bus master
  input  wire logic                      req,
  input  wire logic                      req_write,
  input  wire logic [$clog2(AREAS)-1:0]  req_area,
  input  wire logic [AW-1:0]             req_addr,
  input  wire logic [DW-1:0]             req_wdata,
  output logic                           ack,
  output logic [DW-1:0]                  rdata,
  // Per-area configuration
  input  wire logic [AREAS-1:0]          nand_mode,
  input  wire logic [AREAS-1:0]          mux_mode,
  input  wire logic [AREAS-1:0]          page_mode,
  input  wire logic [AREAS-1:0]          rdy_enable,
  input  wire logic [AREAS-1:0]          oe_width_select,
  input  wire logic [AREAS*32-1:0]       cycle_timing_reg,
  input  wire logic [AREAS*12-1:0]       latch_timing_reg,
  // Memory pins
  output logic [AW-1:0]                  addr_out,
  output logic [DW-1:0]                  data_pins_o,
  output logic                           data_pins_oe,
  input  wire logic [DW-1:0]             data_pins_i,
  output logic [AREAS-1:0]               chip_select_n,
  output logic                           output_enable_n,
  output logic                           write_strobe_n,
  output logic                           addr_latch,
  output logic                           nand_addr_latch,
  output logic                           nand_cmd_latch,
  output logic                           nand_read_strobe_n,
  output logic                           nand_write_strobe_n,
  input  wire logic                      ext_ready_in
);
  import ebnw_pkg::*;

  // The area index must cover every area exactly, and the NAND offset
  // decode needs address bits up to thirteen.
  if (AREAS < 2 || AREAS > 8 || (1 << $clog2(AREAS)) != AREAS ||
      DW < 8 || DW > 16 || AW < 14)
  begin : g_param_check
    $error("ebnw_top: unsupported parameter values");
  end

  ebnw_seq_if s ();

  logic                     busy_r;
  logic                     wr_r;
  logic                     nand_r;
  logic [1:0]               ofs_r;
  logic [$clog2(AREAS)-1:0] area_r;
  logic                     ale_hold_r;
  logic [2:0]               rdy_sh_r;
  logic                     rdy_r;
  logic [31:0]              tim;
  logic [11:0]              atim;
  logic [1:0]               ofs_in;
  logic                     nand_in;

  function automatic logic [3:0] fld(input logic [31:0] w, input int hi);
    fld = w[hi -: 4];
  endfunction

  assign tim     = cycle_timing_reg[area_r*32 +: 32];
  assign atim    = latch_timing_reg[area_r*12 +: 12];
  assign ofs_in  = req_addr[`EBNW_OFS_HI:`EBNW_OFS_LO];
  assign nand_in = nand_mode[req_area];

  // --------------------------------------------------------------------
  // Ready synchroniser
  // --------------------------------------------------------------------
  // The first stage feeds only the second; a level counts once stages two
  // and three agree.
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rdy_sh_r <= 3'h7;
      rdy_r    <= 1'b1;
    end
    else
    begin
      rdy_sh_r <= {rdy_sh_r[1:0], ext_ready_in};
      if (rdy_sh_r[1] == rdy_sh_r[2])
        rdy_r <= rdy_sh_r[2];
    end
  end

  // --------------------------------------------------------------------
  // Access acceptance
  // --------------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      busy_r <= 1'b0;
      wr_r   <= 1'b0;
      nand_r <= 1'b0;
      ofs_r  <= `EBNW_OFS_DATA;
      area_r <= '0;
      ack    <= 1'b0;
    end
    else
    begin
      ack <= 1'b0;
      if (!busy_r && req && !ack)
      begin
        area_r <= req_area;
        wr_r   <= req_write;
        nand_r <= nand_in;
        ofs_r  <= ofs_in;
        // Release write ends at once with no memory cycle.
        if (nand_in && req_write && ofs_in == `EBNW_OFS_RELEASE)
          ack <= 1'b1;
        else
          busy_r <= 1'b1;
      end
      else if (busy_r && s.done)
      begin
        busy_r <= 1'b0;
        ack    <= 1'b1;
      end
    end
  end

  assign s.start    = busy_r && !s.busy && !ack && !s.done;
  assign s.is_write = wr_r;
  // NAND never runs multiplexed; latch timing only applies in mux mode.
  assign s.mux      = mux_mode[area_r] && !nand_r;
  assign s.page     = page_mode[area_r] && !nand_r && !wr_r;
  // Ready is honoured outside page reads and NAND accesses.
  assign s.use_rdy  = rdy_enable[area_r] && !s.page && !nand_r;
  assign s.latch_start_delay     = atim[`EBNW_LATCH_START_DELAY_HI:`EBNW_LATCH_START_DELAY_LO];
  assign s.latch_pulse_width     = atim[`EBNW_LATCH_PULSE_WIDTH_HI:`EBNW_LATCH_PULSE_WIDTH_LO];
  assign s.addr_phase_len      = atim[`EBNW_ALC_HI:`EBNW_ALC_LO];

  // Same timing fields for NAND and SRAM cycles.
  always_comb
  begin
    if (wr_r)
    begin
      s.dly   = fld(tim, `EBNW_WRITE_STROBE_DELAY_HI) + 4'h1;
      s.width = fld(tim, `EBNW_WRITE_PULSE_LEN_HI);
      s.cyc   = fld(tim, `EBNW_WRITE_CYCLE_LEN_HI);
      s.idle  = fld(tim, `EBNW_WRITE_IDLE_LEN_HI);
    end
    else
    begin
      s.cyc  = fld(tim, `EBNW_READ_CYCLE_LEN_HI);
      s.idle = fld(tim, `EBNW_READ_IDLE_LEN_HI);
      if (s.page && !oe_width_select[area_r])
      begin
        s.dly   = fld(tim, `EBNW_READ_STROBE_DELAY_HI) + fld(tim, `EBNW_FIRST_READ_WAIT_HI);
        s.width = fld(tim, `EBNW_READ_CYCLE_LEN_HI);
      end
      else if (!page_mode[area_r] && oe_width_select[area_r])
      begin
        s.dly   = fld(tim, `EBNW_READ_STROBE_DELAY_HI);
        s.width = fld(tim, `EBNW_FIRST_READ_WAIT_HI);
      end
      else
      begin
        s.dly   = fld(tim, `EBNW_READ_STROBE_DELAY_HI);
        // The strobe fills the chip-select time less one hold cycle; a
        // setting with no room left gets the shortest strobe.
        if (fld(tim, `EBNW_READ_CYCLE_LEN_HI) > fld(tim, `EBNW_READ_STROBE_DELAY_HI))
          s.width = fld(tim, `EBNW_READ_CYCLE_LEN_HI) - fld(tim, `EBNW_READ_STROBE_DELAY_HI) -
                    4'h1;
        else
          s.width = 4'h0;
      end
    end
  end

  ebnw_seq u_seq
  (
    .ref_clk  (ref_clk),
    .resetn   (resetn),
    .rdy_sync (rdy_r),
    .s        (s)
  );

  // --------------------------------------------------------------------
  // NAND address latch hold
  // --------------------------------------------------------------------
  // NAND parts cannot see the latch drop between address bytes, so it
  // stays up until a release, data or command write.
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      ale_hold_r <= 1'b0;
    else if (!busy_r && req && !ack && nand_in && req_write)
      ale_hold_r <= (ofs_in == `EBNW_OFS_ADDR);
  end

  // --------------------------------------------------------------------
  // Pin registers
  // --------------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      chip_select_n       <= '1;
      output_enable_n     <= 1'b1;
      write_strobe_n      <= 1'b1;
      nand_read_strobe_n  <= 1'b1;
      nand_write_strobe_n <= 1'b1;
      addr_latch          <= 1'b0;
      nand_addr_latch     <= 1'b0;
      nand_cmd_latch      <= 1'b0;
      addr_out            <= '0;
      data_pins_o         <= '0;
      data_pins_oe        <= 1'b0;
      rdata               <= '0;
    end
    else
    begin
      for (int i = 0; i < AREAS; i++)
        chip_select_n[i] <= !(nand_mode[i] ||
          (busy_r && area_r == i[$clog2(AREAS)-1:0] && s.cs_act));
      output_enable_n     <= !(s.strobe && !wr_r && !nand_r);
      write_strobe_n      <= !(s.strobe && wr_r && !nand_r);
      nand_read_strobe_n  <= !(s.strobe && !wr_r && nand_r);
      nand_write_strobe_n <= !(s.strobe && wr_r && nand_r);
      addr_latch          <= s.ale;
      nand_addr_latch     <= ale_hold_r;
      // Command latch up for the whole addressed span.
      nand_cmd_latch      <= busy_r && nand_r && wr_r &&
                             ofs_r == `EBNW_OFS_CMD && s.cs_act;
      if (s.start)
        addr_out <= req_addr;
      data_pins_oe        <= busy_r && wr_r && s.cs_act;
      if (s.start)
        data_pins_o <= req_wdata;
      if (s.strobe && !wr_r)
        rdata <= data_pins_i;
    end
  end

  AST_RELEASE_NO_CYCLE: assert property (@(posedge ref_clk)
    disable iff (!resetn) (!busy_r && req && !ack && nand_in && req_write &&
    ofs_in == `EBNW_OFS_RELEASE) |=> (ack && !busy_r))
    else $error("release write started a cycle");
  AST_ALE_DROP: assert property (@(posedge ref_clk)
    disable iff (!resetn) (!busy_r && req && !ack && nand_in && req_write &&
    ofs_in != `EBNW_OFS_ADDR) |=> ##1 !nand_addr_latch)
    else $error("address latch not released");
  AST_ALE_SET: assert property (@(posedge ref_clk)
    disable iff (!resetn) (!busy_r && req && !ack && nand_in && req_write &&
    ofs_in == `EBNW_OFS_ADDR) |=> ##1 nand_addr_latch)
    else $error("address latch not raised");
  AST_CS_NAND_LOW: assert property (@(posedge ref_clk)
    disable iff (!resetn) nand_mode[0] |=> !chip_select_n[0])
    else $error("nand chip select went high");
  AST_NAND_NO_OE: assert property (@(posedge ref_clk)
    disable iff (!resetn) !nand_read_strobe_n |-> output_enable_n)
    else $error("ordinary strobe used for nand");
  AST_CLE_DATA: assert property (@(posedge ref_clk)
    disable iff (!resetn) (busy_r && ofs_r == `EBNW_OFS_DATA) |=>
    !nand_cmd_latch)
    else $error("command latch on data cycle");
  AST_NO_MUX_NAND: assert property (@(posedge ref_clk)
    disable iff (!resetn) nand_r && busy_r |-> !s.addr_ph)
    else $error("nand access used mux phase");
  AST_NAND_NO_RDY: assert property (@(posedge ref_clk)
    disable iff (!resetn) nand_r |-> !s.use_rdy)
    else $error("ready honoured in nand mode");

endmodule // ebnw_top
`default_nettype wire
